// ===== gdfr_fault_response.sv
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/1ns
// What this block does
// - Supply undervoltage: gates off, pump off, report
// - Supply recovery automatic; lockout flag stays sticky
// - Pump undervoltage, enabled: gates off, report while present
// - Pump recovery automatic; flags held until clear
// - Pump disabled: flag only, no action
// - Hardware variant: pump protection always on
// - Overcurrent 00: report, gates off, latched
// - Overcurrent 01: report, gates off, retry
// - Overcurrent 10: report only, gates keep running
// - Overcurrent 11: no report, no action
// - Gate stuck enabled: report, gates off, latched
// - Gate stuck disabled: no report, no stop
// - Thermal warning reports when enabled, auto clears
// - Thermal shutdown mode 0: latched gate stop
// - Thermal shutdown mode 1: automatic recovery
// - Passive open load reported when enabled
// - Active open load reported, drivers stay active
// - Offline short test reports supply/ground shorts
// - Memory checksum fault reported, drivers stay active
// - Global fault is OR of all flags
module gdfr_fault_response
    import gdfr_pkg::*;
#(
    parameter bit HW_VARIANT = 1'b0
) (
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              arst_n,
    // Register port
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wr_data,
    input  wire logic              wr_strobe,
    input  wire logic              rd_strobe,
    output logic      [DATA_W-1:0] rd_data,
    // Enable pin, high for normal operation
    input  wire logic              enable,
    // Fault detector levels
    input  wire logic              supply_lockout,
    input  wire logic              pump_undervoltage,
    input  wire logic              drain_source_overcurrent,
    input  wire logic              shunt_overcurrent,
    input  wire logic              gate_stuck_fault,
    input  wire logic              thermal_warning,
    input  wire logic              thermal_shutdown,
    input  wire logic              passive_openload,
    input  wire logic [2:0]        active_openload,
    input  wire logic              short_to_supply,
    input  wire logic              short_to_ground,
    // Power-up memory checksum result
    input  wire logic              mem_check_valid,
    input  wire logic              mem_check_fail,
    // Fault response outputs
    output logic                   fault_out_n,
    output logic                   gate_hiz,
    output logic                   pump_en
);

    gdfr_state_s      st;
    gdfr_state_s      next_st;
    logic [NFLAG-1:0] flag_q;
    logic [NFLAG-1:0] flag_set;
    logic [NFLAG-1:0] flag_clr;
    logic [NFLAG-1:0] held;
    logic             retry_run;
    logic             retry_expire;
    logic             rst_expire;
    logic             enable_pulse;
    logic             clear_faults;
    logic             pump_protect;
    logic             oc_active;
    logic             oc_stop;
    logic             tsd_stop;
    logic             hiz_now;
    logic             report_now;
    logic [DATA_W-1:0] status_word;

    assign pump_protect = HW_VARIANT || !st.pump_uv_disable;

    assign enable_pulse = enable && st.rst_qualified;

    // Clear command from software or a qualified enable pulse
    assign clear_faults = (wr_strobe && addr == CMD_OFS && wr_data[CMD_CLEAR])
                          || enable_pulse;

    // Sources of the sticky flags
    always_comb begin
        flag_set = '0;
        flag_set[FL_SUPPLY] = supply_lockout;
        flag_set[FL_PUMP]   = pump_undervoltage;
        flag_set[FL_DS_OC]  = drain_source_overcurrent
                              && st.overcurrent_action_sel != OC_OFF;
        flag_set[FL_SH_OC]  = shunt_overcurrent
                              && st.overcurrent_action_sel != OC_OFF;
        flag_set[FL_GATE]   = gate_stuck_fault;
        flag_set[FL_TWARN]  = thermal_warning && st.thermal_warn_report_en;
        flag_set[FL_TSD]    = thermal_shutdown;
        flag_set[FL_POL]    = passive_openload && st.passive_openload_en;
        flag_set[FL_AOL_LO +: 3] = active_openload & st.active_openload_en;
        flag_set[FL_SSUP]   = short_to_supply && st.offline_short_test_en;
        flag_set[FL_SGND]   = short_to_ground && st.offline_short_test_en;
        flag_set[FL_MEM]    = mem_check_valid && mem_check_fail;
    end

    // Clears; the memory fault is kept until reset
    always_comb begin
        flag_clr = {NFLAG{clear_faults}};
        flag_clr[FL_MEM] = 1'b0;
        if (retry_expire) begin
            flag_clr[FL_DS_OC] = 1'b1;
            flag_clr[FL_SH_OC] = 1'b1;
        end
    end

    gdfr_flags #(
        .W      (NFLAG)
    ) u_flags (
        .clock  (clock),
        .arst_n (arst_n),
        .set    (flag_set),
        .clr    (flag_clr),
        .q      (flag_q)
    );

    // Live events are folded in so the response does not wait a cycle
    assign held = flag_q | flag_set;

    assign oc_active = held[FL_DS_OC] || held[FL_SH_OC];
    assign retry_run = (st.overcurrent_action_sel == OC_RETRY)
                       && (flag_q[FL_DS_OC] || flag_q[FL_SH_OC]);

    gdfr_timer #(
        .CYC    (RETRY_CYC)
    ) u_retry (
        .clock  (clock),
        .arst_n (arst_n),
        .run    (retry_run),
        .expire (retry_expire)
    );

    gdfr_timer #(
        .CYC    (RST_CYC)
    ) u_rst (
        .clock  (clock),
        .arst_n (arst_n),
        .run    (!enable),
        .expire (rst_expire)
    );

    // Gate stop terms per fault class
    always_comb begin
        oc_stop = oc_active && (st.overcurrent_action_sel == OC_LATCH
                                || st.overcurrent_action_sel == OC_RETRY);
        if (st.thermal_shutdown_recovery_sel) begin
            tsd_stop = thermal_shutdown;
        end else begin
            tsd_stop = held[FL_TSD];
        end
    end

    // Gates go high-impedance on any stopping fault
    always_comb begin
        hiz_now = 1'b0;
        if (supply_lockout) begin
            hiz_now = 1'b1;
        end
        if (pump_undervoltage && pump_protect) begin
            hiz_now = 1'b1;
        end
        if (oc_stop || tsd_stop) begin
            hiz_now = 1'b1;
        end
        if (held[FL_GATE] && !st.gate_stuck_disable) begin
            hiz_now = 1'b1;
        end
    end

    // Fault pin: live terms recover by themselves, held terms need a clear
    always_comb begin
        report_now = 1'b0;
        if (supply_lockout) begin
            report_now = 1'b1;
        end
        if (pump_undervoltage && pump_protect) begin
            report_now = 1'b1;
        end
        if (oc_active) begin
            report_now = 1'b1;
        end
        if (held[FL_GATE] && !st.gate_stuck_disable) begin
            report_now = 1'b1;
        end
        if (thermal_warning && st.thermal_warn_report_en) begin
            report_now = 1'b1;
        end
        if (tsd_stop) begin
            report_now = 1'b1;
        end
        if (held[FL_POL] || held[FL_SSUP] || held[FL_SGND]) begin
            report_now = 1'b1;
        end
        if (|held[FL_AOL_LO +: 3]) begin
            report_now = 1'b1;
        end
        if (held[FL_MEM]) begin
            report_now = 1'b1;
        end
    end

    // Status word seen by software
    always_comb begin
        status_word = '0;
        status_word[ST_GLOBAL] = |flag_q;
        status_word[ST_FLAG_LO +: NFLAG] = flag_q;
        status_word[ST_GATE_HIZ] = st.gate_hiz;
    end

    // Next state: configuration writes, read data, pin drive
    always_comb begin
        next_st = st;
        if (wr_strobe && addr == CFG_OFS) begin
            next_st.pump_uv_disable               = wr_data[CFG_PUMP_DIS];
            next_st.overcurrent_action_sel        = wr_data[CFG_OC_SEL_LO +: 2];
            next_st.gate_stuck_disable            = wr_data[CFG_GATE_DIS];
            next_st.thermal_warn_report_en        = wr_data[CFG_TWARN_REP];
            next_st.thermal_shutdown_recovery_sel = wr_data[CFG_TSD_REC];
            next_st.passive_openload_en           = wr_data[CFG_POL_EN];
            next_st.active_openload_en            = wr_data[CFG_AOL_EN_LO +: 3];
            next_st.offline_short_test_en         = wr_data[CFG_SHORT_EN];
        end
        // Read data stand for one cycle only, zero otherwise
        next_st.rd_data = '0;
        if (rd_strobe) begin
            unique case (addr)
                CFG_OFS: begin
                    next_st.rd_data[CFG_PUMP_DIS]       = st.pump_uv_disable;
                    next_st.rd_data[CFG_OC_SEL_LO +: 2] = st.overcurrent_action_sel;
                    next_st.rd_data[CFG_GATE_DIS]       = st.gate_stuck_disable;
                    next_st.rd_data[CFG_TWARN_REP]      = st.thermal_warn_report_en;
                    next_st.rd_data[CFG_TSD_REC]        = st.thermal_shutdown_recovery_sel;
                    next_st.rd_data[CFG_POL_EN]         = st.passive_openload_en;
                    next_st.rd_data[CFG_AOL_EN_LO +: 3] = st.active_openload_en;
                    next_st.rd_data[CFG_SHORT_EN]       = st.offline_short_test_en;
                end
                STATUS_OFS: begin
                    next_st.rd_data = status_word;
                end
                default: begin
                    next_st.rd_data = '0;
                end
            endcase
        end
        // qualify a long enough low pulse
        if (enable) begin
            next_st.rst_qualified = 1'b0;
        end else if (rst_expire) begin
            next_st.rst_qualified = 1'b1;
        end
        next_st.fault_out_n = !report_now;
        next_st.gate_hiz    = hiz_now;
        next_st.pump_en     = !supply_lockout;
    end

    // State register; outputs start safe with gates in Hi-Z
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            st                        <= '0;
            st.overcurrent_action_sel <= OC_SEL_RST;
            st.fault_out_n            <= FAULT_N_RST;
            st.gate_hiz               <= HIZ_RST;
            st.pump_en                <= PUMP_RST;
        end else begin
            st <= next_st;
        end
    end

    assign rd_data     = st.rd_data;
    assign fault_out_n = st.fault_out_n;
    assign gate_hiz    = st.gate_hiz;
    assign pump_en     = st.pump_en;

endmodule : gdfr_fault_response

// ===== gdfr_pkg.sv
package gdfr_pkg;

    // Register bus shape
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register offsets (byte addresses, one aligned word each)
    localparam logic [7:0] CFG_OFS    = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] CMD_OFS    = 8'h08;

    // Configuration register field positions
    localparam int CFG_PUMP_DIS   = 0;
    localparam int CFG_OC_SEL_LO  = 1;
    localparam int CFG_GATE_DIS   = 3;
    localparam int CFG_TWARN_REP  = 4;
    localparam int CFG_TSD_REC    = 5;
    localparam int CFG_POL_EN     = 6;
    localparam int CFG_AOL_EN_LO  = 7;
    localparam int CFG_SHORT_EN   = 10;

    // Command register: write one to clear latched faults
    localparam int CMD_CLEAR = 0;

    // Status register field positions
    localparam int ST_GLOBAL   = 0;
    localparam int ST_FLAG_LO  = 1;
    localparam int ST_GATE_HIZ = 15;

    // Sticky flag vector layout
    localparam int FL_SUPPLY = 0;
    localparam int FL_PUMP   = 1;
    localparam int FL_DS_OC  = 2;
    localparam int FL_SH_OC  = 3;
    localparam int FL_GATE   = 4;
    localparam int FL_TWARN  = 5;
    localparam int FL_TSD    = 6;
    localparam int FL_POL    = 7;
    localparam int FL_AOL_LO = 8;
    localparam int FL_SSUP   = 11;
    localparam int FL_SGND   = 12;
    localparam int FL_MEM    = 13;
    localparam int NFLAG     = 14;

    // Overcurrent action encodings
    localparam logic [1:0] OC_LATCH  = 2'h0;
    localparam logic [1:0] OC_RETRY  = 2'h1;
    localparam logic [1:0] OC_REPORT = 2'h2;
    localparam logic [1:0] OC_OFF    = 2'h3;

    // Reset values
    localparam logic [1:0] OC_SEL_RST = OC_LATCH;
    localparam logic       FAULT_N_RST = 1'h1;
    localparam logic       HIZ_RST     = 1'h1;
    localparam logic       PUMP_RST    = 1'h1;

    // Timing: figures in their own unit, counts derived from the clock
    localparam int CLK_PERIOD_NS = 20;
    localparam int T_RETRY_US    = 4;
    localparam int T_RST_US      = 8;
    localparam int RETRY_CYC = (T_RETRY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RST_CYC   = (T_RST_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TIMER_W   = 16;

    // All registered state of the top module
    typedef struct packed {
        logic              pump_uv_disable;
        logic [1:0]        overcurrent_action_sel;
        logic              gate_stuck_disable;
        logic              thermal_warn_report_en;
        logic              thermal_shutdown_recovery_sel;
        logic              passive_openload_en;
        logic [2:0]        active_openload_en;
        logic              offline_short_test_en;
        logic              rst_qualified;
        logic              fault_out_n;
        logic              gate_hiz;
        logic              pump_en;
        logic [DATA_W-1:0] rd_data;
    } gdfr_state_s;

endpackage : gdfr_pkg

// ===== gdfr_flags.sv
`timescale 1ns/1ns
// Vector of sticky flags; a set in the same cycle as a clear wins
module gdfr_flags
    import gdfr_pkg::*;
#(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clock,
    input  wire logic         arst_n,
    // Flag control
    input  wire logic [W-1:0] set,
    input  wire logic [W-1:0] clr,
    // Flag state
    output logic      [W-1:0] q
);

    logic [W-1:0] state;
    logic [W-1:0] next_state;

    // Set beats clear so no event is lost during a clear
    always_comb begin
        next_state = set | (state & ~clr);
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign q = state;

endmodule : gdfr_flags

// ===== gdfr_timer.sv
`timescale 1ns/1ns
// Free counter that pulses expire every CYC cycles while run is high
module gdfr_timer
    import gdfr_pkg::*;
#(
    parameter int CYC = 2
) (
    // Clock and reset
    input  wire logic clock,
    input  wire logic arst_n,
    // Control
    input  wire logic run,
    output logic      expire
);

    logic [TIMER_W-1:0] count;
    logic [TIMER_W-1:0] next_count;
    logic               at_end;

    assign at_end = (count == TIMER_W'(CYC - 1));
    assign expire = run && at_end;

    // Restart from zero whenever run drops or the interval ends
    always_comb begin
        if (!run || at_end) begin
            next_count = '0;
        end else begin
            next_count = count + TIMER_W'(1);
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

endmodule : gdfr_timer

// ===== gdfr_fault_response_props.sv
`timescale 1ns/1ns
module gdfr_fault_response_props
    import gdfr_pkg::*;
#(
    parameter bit HW_VARIANT = 1'b0
) (
    // Clock and reset
    input wire logic              clock,
    input wire logic              arst_n,
    // Register port
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wr_data,
    input wire logic              wr_strobe,
    input wire logic              rd_strobe,
    input wire logic [DATA_W-1:0] rd_data,
    // Detectors
    input wire logic              supply_lockout,
    input wire logic              pump_undervoltage,
    input wire logic              drain_source_overcurrent,
    input wire logic              shunt_overcurrent,
    input wire logic              gate_stuck_fault,
    input wire logic              thermal_warning,
    input wire logic              thermal_shutdown,
    input wire logic              mem_check_valid,
    input wire logic              mem_check_fail,
    // Responses
    input wire logic              fault_out_n,
    input wire logic              gate_hiz,
    input wire logic              pump_en
);
    logic [10:0] cfg;
    logic [1:0]  oc_mode;
    logic        oc_now;
    logic        pump_prot;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);

    // Shadow config; old value still governs the write cycle, as in the block
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cfg <= 11'h000;
        end else if (wr_strobe && addr == CFG_OFS) begin
            cfg <= wr_data[10:0];
        end
    end

    // Decoded conditions
    assign oc_mode   = cfg[2:1];
    assign oc_now    = drain_source_overcurrent | shunt_overcurrent;
    assign pump_prot = pump_undervoltage & (HW_VARIANT | ~cfg[CFG_PUMP_DIS]);

    a_supply_off:
        assert property (supply_lockout |=> gate_hiz && !fault_out_n && !pump_en)
        else $error("supply undervoltage left gates or pump running");
    a_pump_runs:
        assert property (!supply_lockout |=> pump_en)
        else $error("charge pump off without supply undervoltage");
    a_pump_stop:
        assert property (pump_prot |=> gate_hiz && !fault_out_n)
        else $error("pump undervoltage did not stop gates");
    a_oc_latch:
        assert property (oc_now && oc_mode == OC_LATCH |=> gate_hiz && !fault_out_n)
        else $error("latched overcurrent did not stop gates");
    a_oc_report:
        assert property (oc_now && oc_mode == OC_REPORT |=> !fault_out_n)
        else $error("report-only overcurrent not on fault pin");
    a_gate_stop:
        assert property (gate_stuck_fault && !cfg[CFG_GATE_DIS] |=> gate_hiz && !fault_out_n)
        else $error("gate stuck fault did not stop gates");
    a_warn_pin:
        assert property (thermal_warning && cfg[CFG_TWARN_REP] |=> !fault_out_n)
        else $error("thermal warning not reported");
    a_tsd_stop:
        assert property (thermal_shutdown |=> gate_hiz && !fault_out_n)
        else $error("thermal shutdown did not stop gates");
    a_mem_pin:
        assert property (mem_check_valid && mem_check_fail |=> (!fault_out_n) [*8])
        else $error("checksum fault not held on fault pin");
    a_global_or:
        assert property (rd_strobe && addr == STATUS_OFS |=> rd_data[0] == |rd_data[14:1])
        else $error("global fault bit differs from OR of flags");

    // Main scenarios
    c_retry: cover property (oc_now && oc_mode == OC_RETRY ##1 gate_hiz);
    c_status: cover property (rd_strobe && addr == STATUS_OFS ##1 rd_data[ST_GLOBAL]);
    c_mem: cover property (mem_check_valid && mem_check_fail);
endmodule : gdfr_fault_response_props

bind gdfr_fault_response gdfr_fault_response_props #(
    .HW_VARIANT(HW_VARIANT)
) gdfr_fault_response_props_inst (
    .clock, .arst_n, .addr, .wr_data, .wr_strobe, .rd_strobe, .rd_data,
    .supply_lockout, .pump_undervoltage, .drain_source_overcurrent, .shunt_overcurrent,
    .gate_stuck_fault, .thermal_warning, .thermal_shutdown, .mem_check_valid,
    .mem_check_fail, .fault_out_n, .gate_hiz, .pump_en
);

// ===== gdfr_bridge_model.sv
`timescale 1ns/1ns
module gdfr_bridge_model (
    // Gate command from the block
    input  wire logic gate_hiz,
    // Short injected by the bench
    input  wire logic short_cmd,
    // Detector level back to the block
    output logic      drain_source_overcurrent
);
    // Current only flows while the gates conduct, so Hi-Z removes the condition
    assign drain_source_overcurrent = short_cmd & ~gate_hiz;
endmodule : gdfr_bridge_model

// ===== tb_gdfr_fault_response.sv
`timescale 1ns/1ns
module tb_gdfr_fault_response
    import gdfr_pkg::*;
;
    logic              clock;
    logic              arst_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wr_data;
    logic              wr_strobe;
    logic              rd_strobe;
    logic [DATA_W-1:0] rd_data;
    logic              enable;
    logic              supply_lockout;
    logic              pump_undervoltage;
    logic              drain_source_overcurrent;
    logic              shunt_overcurrent;
    logic              gate_stuck_fault;
    logic              thermal_warning;
    logic              thermal_shutdown;
    logic [5:0]        report_det;
    logic              mem_check_valid;
    logic              mem_check_fail;
    logic              fault_out_n;
    logic              gate_hiz;
    logic              pump_en;
    logic              short_cmd;
    logic              rd_pend = 1'b0;
    logic [DATA_W-1:0] rd_exp_q[$];
    int                bad_count;
    int                samples_checked;
    int                seed;

    gdfr_fault_response gdfr_fault_response_inst (
        .clock, .arst_n, .addr, .wr_data, .wr_strobe, .rd_strobe, .rd_data, .enable,
        .supply_lockout, .pump_undervoltage, .drain_source_overcurrent, .shunt_overcurrent,
        .gate_stuck_fault, .thermal_warning, .thermal_shutdown,
        .passive_openload(report_det[0]), .active_openload(report_det[3:1]),
        .short_to_supply(report_det[4]), .short_to_ground(report_det[5]),
        .mem_check_valid, .mem_check_fail, .fault_out_n, .gate_hiz, .pump_en
    );

    gdfr_bridge_model gdfr_bridge_model_inst (.gate_hiz, .short_cmd, .drain_source_overcurrent);

    // 50 MHz clock
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    task automatic check(input string name, input logic [DATA_W-1:0] seen,
                         input logic [DATA_W-1:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : print_verdict

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clock);
        addr      <= a;
        wr_data   <= d;
        wr_strobe <= 1'b1;
        @(posedge clock);
        wr_strobe <= 1'b0;
    endtask : wr

    // Read notes its expectation; the monitor below does the compare
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        @(posedge clock);
        addr      <= a;
        rd_strobe <= 1'b1;
        rd_exp_q.push_back(e);
        @(posedge clock);
        rd_strobe <= 1'b0;
    endtask : rd

    // Pins: fault, Hi-Z, pump, after outputs have settled
    task automatic pins(input logic f_n, input logic hiz, input logic pump);
        repeat (2) @(posedge clock);
        #1;
        check("pins", {29'h0, fault_out_n, gate_hiz, pump_en}, {29'h0, f_n, hiz, pump});
    endtask : pins

    // Read data stands only in the cycle after the strobe
    always @(posedge clock) begin
        if (rd_pend) begin
            check("rd_data", rd_data, rd_exp_q.pop_front());
        end
        rd_pend <= rd_strobe;
    end

    // Hang guard
    initial begin
        repeat (50000) @(posedge clock);
        bad_count++;
        print_verdict();
    end

    // Main sequence
    initial begin
        int m;
        int k;
        int b;
        {addr, wr_data, wr_strobe, rd_strobe, supply_lockout, pump_undervoltage} = '0;
        {shunt_overcurrent, gate_stuck_fault, thermal_warning, thermal_shutdown} = '0;
        {report_det, mem_check_valid, mem_check_fail, short_cmd} = '0;
        enable = 1'b1;
        arst_n = 1'b0;
        bad_count = 0;
        samples_checked = 0;
        seed = 75;
        repeat (2) @(posedge clock);
        arst_n <= 1'b1;
        rd(CFG_OFS, 32'h0);
        wr(CFG_OFS, 32'($random(seed)) & 32'h0000_07FF);
        rd(CFG_OFS, wr_data);
        wr(STATUS_OFS, 32'hFFFF_FFFF);
        rd(STATUS_OFS, 32'h0);
        rd(8'h0C, 32'h0);
        rd(CMD_OFS, 32'h0);
        wr(CFG_OFS, 32'h0);
        // Supply undervoltage
        @(posedge clock) supply_lockout <= 1'b1;
        pins(1'b0, 1'b1, 1'b0);
        rd(STATUS_OFS, 32'h0000_8003);
        @(posedge clock) supply_lockout <= 1'b0;
        pins(1'b1, 1'b0, 1'b1);
        rd(STATUS_OFS, 32'h0000_0003);
        wr(CMD_OFS, 32'h1);
        rd(STATUS_OFS, 32'h0);
        // Pump undervoltage, protected then flag-only
        for (m = 0; m < 2; m++) begin
            wr(CFG_OFS, m[0] ? 32'h1 : 32'h0);
            @(posedge clock) pump_undervoltage <= 1'b1;
            pins(m[0], !m[0], 1'b1);
            @(posedge clock) pump_undervoltage <= 1'b0;
            pins(1'b1, 1'b0, 1'b1);
            rd(STATUS_OFS, 32'h0000_0005);
            wr(CMD_OFS, 32'h1);
        end
        // Overcurrent modes; even modes via the bridge, odd via the shunt
        for (m = 0; m < 4; m++) begin
            wr(CFG_OFS, 32'(m) << CFG_OC_SEL_LO);
            @(posedge clock);
            short_cmd <= !m[0];
            shunt_overcurrent <= m[0];
            pins(m == 3, m < 2, 1'b1);
            @(posedge clock);
            short_cmd <= 1'b0;
            shunt_overcurrent <= 1'b0;
            if (m == 1) begin
                repeat (RETRY_CYC / 2) @(posedge clock);
                pins(1'b0, 1'b1, 1'b1);
                repeat (RETRY_CYC / 2) @(posedge clock);
                pins(1'b1, 1'b0, 1'b1);
            end else begin
                pins(m == 3, m == 0, 1'b1);
            end
            wr(CMD_OFS, 32'h1);
            pins(1'b1, 1'b0, 1'b1);
        end
        // Gate stuck, warning and shutdown, each with its option off then on
        for (m = 0; m < 2; m++) begin
            wr(CFG_OFS, 32'(m) << CFG_GATE_DIS);
            @(posedge clock) gate_stuck_fault <= 1'b1;
            pins(m[0], !m[0], 1'b1);
            @(posedge clock) gate_stuck_fault <= 1'b0;
            pins(m[0], !m[0], 1'b1);
            wr(CMD_OFS, 32'h1);
            pins(1'b1, 1'b0, 1'b1);
            wr(CFG_OFS, 32'(m) << CFG_TWARN_REP);
            @(posedge clock) thermal_warning <= 1'b1;
            pins(!m[0], 1'b0, 1'b1);
            @(posedge clock) thermal_warning <= 1'b0;
            pins(1'b1, 1'b0, 1'b1);
            wr(CMD_OFS, 32'h1);
            wr(CFG_OFS, 32'(m) << CFG_TSD_REC);
            @(posedge clock) thermal_shutdown <= 1'b1;
            pins(1'b0, 1'b1, 1'b1);
            @(posedge clock) thermal_shutdown <= 1'b0;
            pins(m[0], !m[0], 1'b1);
            wr(CMD_OFS, 32'h1);
            pins(1'b1, 1'b0, 1'b1);
        end
        // Report-only detectors, each with its enable off then on
        for (k = 0; k < 6; k++) begin
            b = (k == 0) ? CFG_POL_EN : (k < 4) ? CFG_AOL_EN_LO + k - 1 : CFG_SHORT_EN;
            for (m = 0; m < 2; m++) begin
                wr(CFG_OFS, 32'(m) << b);
                @(posedge clock) report_det <= 6'h01 << k;
                pins(!m[0], 1'b0, 1'b1);
                @(posedge clock) report_det <= 6'h00;
                pins(!m[0], 1'b0, 1'b1);
                wr(CMD_OFS, 32'h1);
                pins(1'b1, 1'b0, 1'b1);
            end
        end
        // Enable pulse: too short keeps the latch, long enough clears it
        wr(CFG_OFS, 32'h0);
        @(posedge clock) gate_stuck_fault <= 1'b1;
        @(posedge clock) gate_stuck_fault <= 1'b0;
        @(posedge clock) enable <= 1'b0;
        repeat (RST_CYC / 2) @(posedge clock);
        enable <= 1'b1;
        pins(1'b0, 1'b1, 1'b1);
        @(posedge clock) enable <= 1'b0;
        repeat (RST_CYC + 2) @(posedge clock);
        enable <= 1'b1;
        pins(1'b1, 1'b0, 1'b1);
        // Checksum fault survives a clear; only reset removes it
        @(posedge clock);
        mem_check_valid <= 1'b1;
        mem_check_fail <= 1'b1;
        @(posedge clock);
        mem_check_valid <= 1'b0;
        mem_check_fail <= 1'b0;
        wr(CMD_OFS, 32'h1);
        pins(1'b0, 1'b0, 1'b1);
        rd(STATUS_OFS, 32'h0000_4001);
        @(posedge clock) arst_n <= 1'b0;
        pins(1'b1, 1'b1, 1'b1);
        @(posedge clock) arst_n <= 1'b1;
        pins(1'b1, 1'b0, 1'b1);
        rd(STATUS_OFS, 32'h0);
        repeat (3) @(posedge clock);
        print_verdict();
    end
endmodule : tb_gdfr_fault_response
